// ===== verilog/rpg_pkg.sv
/*
  Package for the resolver reference PWM generator: register map, field layout,
  reset values, channel state enumeration and the packed carriers.
  Assumes a 32-bit AHB-Lite register bus and a 250 MHz bus clock.
*/
`default_nettype none

package rpg_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets (byte addresses, one aligned word each).
  localparam logic [11:0] RPG_CTRL_OFS = 12'h000; // Run bits, one per channel.
  localparam logic [11:0] RPG_STAT_OFS = 12'h004; // Run and pin levels.
  localparam logic [11:0] RPG_PA_PER_OFS = 12'h008; // Phase signal period compare.
  localparam logic [11:0] RPG_PA_DUTY_OFS = 12'h00c; // Phase signal duty compare.
  localparam logic [11:0] RPG_AC_PER_OFS = 12'h010; // Correction period compare.
  localparam logic [11:0] RPG_AC_DUTY_OFS = 12'h014; // Correction duty compare.
  localparam logic [11:0] RPG_CNT_OFS = 12'h018; // Both counters, read only.

  ////////////////////////////////////////////////////////////////////////////
  // Widths and field positions.
  localparam int RPG_CW = 16; // Counter and compare width.
  localparam int RPG_NCH = 2; // Channel 0 phase, channel 1 correction.
  localparam int RPG_CH_PA = 0;
  localparam int RPG_CH_AC = 1;
  localparam int RPG_STAT_PIN_LSB = 4; // Pin levels sit at bits 5:4 of status.
  localparam int RPG_CNT_HI_LSB = 16; // Correction counter in upper half.

  ////////////////////////////////////////////////////////////////////////////
  // Timing: the count clock is the 250 MHz bus clock.
  localparam int RPG_CLK_KHZ = 250000;
  localparam int RPG_PA_PERIOD_NS = 2500; // 400 kHz phase adjustment period.
  localparam int RPG_PA_HIGH_NS = 1250; // High time of the phase signal.
  localparam int RPG_AC_PERIOD_NS = 5000; // 200 kHz correction period.
  // Period compare is cycles minus one, since the match restarts at zero.
  localparam logic [15:0] RPG_PA_PER_RST = 16'(RPG_PA_PERIOD_NS * RPG_CLK_KHZ / 1000000 - 1);
  localparam logic [15:0] RPG_PA_DUTY_RST = 16'(RPG_PA_HIGH_NS * RPG_CLK_KHZ / 1000000 - 1);
  localparam logic [15:0] RPG_AC_PER_RST = 16'(RPG_AC_PERIOD_NS * RPG_CLK_KHZ / 1000000 - 1);
  localparam logic [15:0] RPG_AC_DUTY_RST = 16'((RPG_AC_PER_RST + 16'h0001) / 2 - 1);
  // Printed compare sets for software to load, at the 60 MHz count clock.
  localparam logic [15:0] RPG_ALT_PA_PER = 16'h0095; // 149.
  localparam logic [15:0] RPG_ALT_PA_DUTY = 16'h004e; // 78.
  localparam logic [15:0] RPG_ALT_AC_PER = 16'h0257; // 599.
  localparam logic [15:0] RPG_ALT_AC_DUTY = 16'h012b; // 299.

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite encodings.
  localparam logic [1:0] RPG_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] RPG_HSIZE_WORD = 3'h2;

  // Channel state, one-hot.
  typedef enum logic [1:0] {
    RPG_ST_STOP = 2'b01,
    RPG_ST_RUN = 2'b10
  } rpg_state_t;

  // Compare pair of one channel.
  typedef struct packed {
    logic [15:0] per;
    logic [15:0] duty;
  } rpg_cmp_t;

  // Latched AHB address phase.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
  } rpg_aph_t;

endpackage : rpg_pkg

`default_nettype wire

// ===== verilog/rpg_top.sv
/*
  Resolver reference PWM generator: two independent up-counting channels that
  drive the phase adjustment and angle error correction signals to a resolver
  converter. Assumes a single AHB-Lite master on hclk, the bus fabric driving
  hsel, and the board wiring only the two signal pins to the converter.
*/
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// R1: counter counts clock, clears on period match
// R2: period match drives the output high
// R3: duty match drives the output low
// R4: phase signal repeats at 400 kHz
// R5: alternative compare set 149 and 78
// R6: pin rests high before counting
// R7: correction signal runs at 200 kHz
// R8: correction compares 599 and 299, half duty
// R9: only the designated output drives a pin
// R10: no interrupts and no conversion triggers
// R11: channels count independently, no coupling
// R12: compares loaded stopped, start from zero
module rpg_top
  import rpg_pkg::*;
(
  // Clock, reset and clock enable.
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Signals to the resolver converter.
  output logic phase_adj_out,
  output logic phase_adj_oe,
  output logic angle_corr_out,
  output logic angle_corr_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.

  // Latched address phase of the transfer now in its data phase.
  rpg_aph_t aph_ff;
  // Compare registers of both channels.
  rpg_cmp_t cmp_ff [RPG_NCH];
  // Per-channel counters, pin levels and states.
  logic [RPG_CW-1:0] cnt_ff [RPG_NCH];
  logic [RPG_NCH-1:0] pin_ff;
  rpg_state_t st_ff [RPG_NCH];
  // Run bits written by software.
  logic [RPG_NCH-1:0] run_ff;
  // Read data register.
  logic [31:0] rdata_ff;
  // Decoded next read value.
  logic [31:0] nxt_rdata;

  // Tells whether a write of this address hits the given register offset.
  function automatic logic cmp_hit(input logic [11:0] a, input logic [11:0] ofs);
    cmp_hit = (a == ofs);
  endfunction : cmp_hit

  ////////////////////////////////////////////////////////////////////////////
  // Bus address phase. The slave is always ready, so every phase is one cycle.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aph_ff <= '0;
    end else if (clk_en) begin
      if (hready) begin
        // Only word writes are honoured; other writes complete with no effect, while reads of any size are served.
        aph_ff.wr <= hsel && (htrans == RPG_HTRANS_NONSEQ) && hwrite && (hsize == RPG_HSIZE_WORD);
        aph_ff.rd <= hsel && (htrans == RPG_HTRANS_NONSEQ) && !hwrite;
        aph_ff.addr <= haddr[11:0];
      end
    end
  end

  // Response is always zero wait-state OKAY, so both come from constant flops.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Run control register, written in the data phase.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_ff <= '0;
    end else if (clk_en) begin
      if (aph_ff.wr && cmp_hit(aph_ff.addr, RPG_CTRL_OFS)) begin
        run_ff <= hwdata[RPG_NCH-1:0];
      end
    end
  end

  // Compare registers. Writes are accepted only while that channel is stopped,
  // so a running waveform never sees a half-updated period and duty pair.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      // R4 R7: reset frequencies
      // Reset compares give 400 kHz and 200 kHz straight from the bus clock.
      cmp_ff[RPG_CH_PA] <= '{per: RPG_PA_PER_RST, duty: RPG_PA_DUTY_RST};
      cmp_ff[RPG_CH_AC] <= '{per: RPG_AC_PER_RST, duty: RPG_AC_DUTY_RST};
    end else if (clk_en && aph_ff.wr) begin
      // R5 R8: software compare sets
      // Sets meant for a slower count clock load here like any other value.
      // R12: loads while stopped
      if (st_ff[RPG_CH_PA] == RPG_ST_STOP) begin
        if (cmp_hit(aph_ff.addr, RPG_PA_PER_OFS)) begin
          cmp_ff[RPG_CH_PA].per <= hwdata[RPG_CW-1:0];
        end
        if (cmp_hit(aph_ff.addr, RPG_PA_DUTY_OFS)) begin
          cmp_ff[RPG_CH_PA].duty <= hwdata[RPG_CW-1:0];
        end
      end
      if (st_ff[RPG_CH_AC] == RPG_ST_STOP) begin
        if (cmp_hit(aph_ff.addr, RPG_AC_PER_OFS)) begin
          cmp_ff[RPG_CH_AC].per <= hwdata[RPG_CW-1:0];
        end
        if (cmp_hit(aph_ff.addr, RPG_AC_DUTY_OFS)) begin
          cmp_ff[RPG_CH_AC].duty <= hwdata[RPG_CW-1:0];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channels. Each has its own counter, pin and state with no shared start or
  // clear, and none produces an interrupt or conversion trigger.
  // R10: no event outputs
  // R11: independent channels
  for (genvar ch = 0; ch < RPG_NCH; ch++) begin : g_ch
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        st_ff[ch] <= RPG_ST_STOP;
        cnt_ff[ch] <= '0;
        // R6: rests high
        pin_ff[ch] <= 1'b1;
      end else if (clk_en) begin
        case (st_ff[ch])
          RPG_ST_STOP: begin
            // R12: start from zero
            cnt_ff[ch] <= '0;
            pin_ff[ch] <= 1'b1;
            if (run_ff[ch]) begin
              st_ff[ch] <= RPG_ST_RUN;
            end
          end
          RPG_ST_RUN: begin
            if (!run_ff[ch]) begin
              // Stopping returns the pin to its resting high level.
              st_ff[ch] <= RPG_ST_STOP;
              cnt_ff[ch] <= '0;
              pin_ff[ch] <= 1'b1;
            end else if (cnt_ff[ch] == cmp_ff[ch].per) begin
              // R1: clear on period match
              cnt_ff[ch] <= '0;
              // R2: high at period match
              pin_ff[ch] <= 1'b1;
            end else begin
              cnt_ff[ch] <= cnt_ff[ch] + 16'h0001;
              // R3: low at duty match
              if (cnt_ff[ch] == cmp_ff[ch].duty) begin
                pin_ff[ch] <= 1'b0;
              end
            end
          end
          default: begin
            st_ff[ch] <= RPG_ST_STOP;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins. Only the one designated output per channel is enabled.
  // R4 R7: pins follow channels
  // R9: single designated output
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_adj_out <= 1'b1;
      angle_corr_out <= 1'b1;
      phase_adj_oe <= 1'b1;
      angle_corr_oe <= 1'b1;
    end else if (clk_en) begin
      phase_adj_out <= pin_ff[RPG_CH_PA];
      angle_corr_out <= pin_ff[RPG_CH_AC];
      phase_adj_oe <= 1'b1;
      angle_corr_oe <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux. Unmapped offsets read as zero.
  always_comb begin
    nxt_rdata = '0;
    case (haddr[11:0])
      RPG_CTRL_OFS: nxt_rdata = {30'h0, run_ff};
      RPG_STAT_OFS: begin
        nxt_rdata[RPG_NCH-1:0] = {st_ff[1] == RPG_ST_RUN, st_ff[0] == RPG_ST_RUN};
        nxt_rdata[RPG_STAT_PIN_LSB +: RPG_NCH] = pin_ff;
      end
      RPG_PA_PER_OFS: nxt_rdata = {16'h0, cmp_ff[RPG_CH_PA].per};
      RPG_PA_DUTY_OFS: nxt_rdata = {16'h0, cmp_ff[RPG_CH_PA].duty};
      RPG_AC_PER_OFS: nxt_rdata = {16'h0, cmp_ff[RPG_CH_AC].per};
      RPG_AC_DUTY_OFS: nxt_rdata = {16'h0, cmp_ff[RPG_CH_AC].duty};
      RPG_CNT_OFS: nxt_rdata = {cnt_ff[RPG_CH_AC], cnt_ff[RPG_CH_PA]};
      default: nxt_rdata = '0;
    endcase
  end

  // Read data is captured at the end of the address phase and held.
  // This keeps hrdata a plain flop; the cost is that a counter read shows
  // the count as it stood one cycle before the data phase.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_ff <= '0;
    end else if (clk_en && hready && hsel && (htrans == RPG_HTRANS_NONSEQ) && !hwrite) begin
      rdata_ff <= nxt_rdata;
    end
  end

  always_comb begin
    hrdata = rdata_ff;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions. Each watches state the design drives; reset disables them all.

  // R1: phase counter clears
  AST_CNT_CLEAR: assert property (@(posedge hclk) disable iff (!hresetn) // R1
    clk_en && st_ff[0] == RPG_ST_RUN && run_ff[0] && cnt_ff[0] == cmp_ff[0].per
    |=> cnt_ff[0] == '0) else $error("Phase counter did not clear on period match.");

  // R1: correction counter clears
  AST_AC_CLEAR: assert property (@(posedge hclk) disable iff (!hresetn) // R1
    clk_en && st_ff[1] == RPG_ST_RUN && run_ff[1] && cnt_ff[1] == cmp_ff[1].per
    |=> cnt_ff[1] == '0) else $error("Correction counter did not clear.");

  // R2: correction high at wrap
  AST_PIN_HIGH: assert property (@(posedge hclk) disable iff (!hresetn) // R2
    clk_en && st_ff[1] == RPG_ST_RUN && run_ff[1] && cnt_ff[1] == cmp_ff[1].per
    |=> pin_ff[1]) else $error("Correction pin not high after period match.");

  // R2: phase high at wrap
  AST_PA_HIGH: assert property (@(posedge hclk) disable iff (!hresetn) // R2
    clk_en && st_ff[0] == RPG_ST_RUN && run_ff[0] && cnt_ff[0] == cmp_ff[0].per
    |=> pin_ff[0]) else $error("Phase pin not high after period match.");

  // R3: phase low at duty
  AST_PIN_LOW: assert property (@(posedge hclk) disable iff (!hresetn) // R3
    clk_en && st_ff[0] == RPG_ST_RUN && run_ff[0] && cnt_ff[0] == cmp_ff[0].duty
    && cnt_ff[0] != cmp_ff[0].per |=> !pin_ff[0]) else $error("Phase pin not low at duty.");

  // R3: correction low at duty
  AST_AC_LOW: assert property (@(posedge hclk) disable iff (!hresetn) // R3
    clk_en && st_ff[1] == RPG_ST_RUN && run_ff[1] && cnt_ff[1] == cmp_ff[1].duty
    && cnt_ff[1] != cmp_ff[1].per |=> !pin_ff[1]) else $error("Correction pin not low.");

  // R6: stopped phase rests
  AST_STOP_HIGH: assert property (@(posedge hclk) disable iff (!hresetn) // R6
    st_ff[0] == RPG_ST_STOP && $past(st_ff[0]) == RPG_ST_STOP |-> pin_ff[0] && cnt_ff[0] == '0)
    else $error("Stopped phase channel not at rest.");

  // R6: stopped correction rests
  AST_AC_STOP_HIGH: assert property (@(posedge hclk) disable iff (!hresetn) // R6
    st_ff[1] == RPG_ST_STOP && $past(st_ff[1]) == RPG_ST_STOP |-> pin_ff[1] && cnt_ff[1] == '0)
    else $error("Stopped correction channel not at rest.");

  // R9: designated outputs enabled
  AST_OE_ON: assert property (@(posedge hclk) disable iff (!hresetn) // R9
    phase_adj_oe && angle_corr_oe)
    else $error("Designated output disabled.");

  // R12: phase compares locked
  AST_CMP_LOCK: assert property (@(posedge hclk) disable iff (!hresetn) // R12
    st_ff[0] == RPG_ST_RUN && $past(st_ff[0]) == RPG_ST_RUN |-> $stable(cmp_ff[0]))
    else $error("Compare changed while running.");

  // R12: correction compares locked
  AST_AC_CMP_LOCK: assert property (@(posedge hclk) disable iff (!hresetn) // R12
    st_ff[1] == RPG_ST_RUN && $past(st_ff[1]) == RPG_ST_RUN |-> $stable(cmp_ff[1]))
    else $error("Correction compare changed while running.");

  // R12: correction starts at zero
  AST_START_ZERO: assert property (@(posedge hclk) disable iff (!hresetn) // R12
    $rose(st_ff[1] == RPG_ST_RUN) |-> cnt_ff[1] == '0)
    else $error("Start not from zero.");

  // R12: phase starts at zero
  AST_PA_START_ZERO: assert property (@(posedge hclk) disable iff (!hresetn) // R12
    $rose(st_ff[0] == RPG_ST_RUN) |-> cnt_ff[0] == '0 && pin_ff[0])
    else $error("Phase start not from zero.");

  // R11: correction ignores phase stop
  AST_INDEP: assert property (@(posedge hclk) disable iff (!hresetn) // R11
    clk_en && run_ff[1] && st_ff[1] == RPG_ST_RUN && cnt_ff[1] != cmp_ff[1].per
    && $fell(run_ff[0]) |=> cnt_ff[1] == $past(cnt_ff[1]) + 16'h0001)
    else $error("Channel coupling seen.");

  // R11: phase ignores correction stop
  AST_PA_INDEP: assert property (@(posedge hclk) disable iff (!hresetn) // R11
    clk_en && run_ff[0] && st_ff[0] == RPG_ST_RUN && cnt_ff[0] != cmp_ff[0].per
    && $fell(run_ff[1]) |=> cnt_ff[0] == $past(cnt_ff[0]) + 16'h0001)
    else $error("Phase channel coupled to correction stop.");

  // R4: phase pin follows
  AST_OUT_FOLLOW: assert property (@(posedge hclk) disable iff (!hresetn) // R4
    clk_en |=> phase_adj_out == $past(pin_ff[0]))
    else $error("Pin output lags wrongly.");

  // R7: correction pin follows
  AST_AC_OUT_FOLLOW: assert property (@(posedge hclk) disable iff (!hresetn) // R7
    clk_en |=> angle_corr_out == $past(pin_ff[1]))
    else $error("Correction pin output lags wrongly.");

  // R10: plain OKAY, no events
  AST_BUS_OK: assert property (@(posedge hclk) disable iff (!hresetn) // R10
    hreadyout && !hresp)
    else $error("Bus response not OKAY.");

  // R1: count only when enabled
  AST_FREEZE: assert property (@(posedge hclk) disable iff (!hresetn) // R1
    !clk_en |=> $stable(cnt_ff[0]) && $stable(cnt_ff[1]) && $stable(pin_ff) && $stable(run_ff))
    else $error("State moved while the clock enable was low.");

  // Main scenarios: wrap, correction low edge, both running, stop and freeze.
  COV_PA_WRAP: cover property (@(posedge hclk) disable iff (!hresetn)
    st_ff[0] == RPG_ST_RUN && cnt_ff[0] == cmp_ff[0].per);
  COV_AC_LOW: cover property (@(posedge hclk) disable iff (!hresetn) $fell(pin_ff[1]));
  COV_BOTH_RUN: cover property (@(posedge hclk) disable iff (!hresetn) &run_ff);
  COV_STOP: cover property (@(posedge hclk) disable iff (!hresetn) $fell(run_ff[0]));
  COV_FREEZE: cover property (@(posedge hclk) disable iff (!hresetn)
    !clk_en && st_ff[0] == RPG_ST_RUN);

endmodule : rpg_top

`default_nettype wire

// ===== dv/rpg_rdc_model.sv
/*
  Behavioural model of the resolver converter input that receives one
  reference signal: it measures period and high time in clock cycles.
  Assumes the reference pin is registered on hclk and has a board pull-up.
*/
`timescale 1ns/1ns
`default_nettype none

module rpg_rdc_model (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // Reference pin and its enable.
  input wire logic ref_pin,
  input wire logic ref_oe,
  // Last period, last high time and number of rising edges seen.
  output logic [15:0] per_ff,
  output logic [15:0] hi_ff,
  output logic [15:0] rise_ff
);
  logic lvl; // Level seen at the converter input.
  logic prev_ff; // Level one cycle earlier.
  logic [15:0] cnt_ff; // Cycles since the last rising edge.

  // An undriven pin floats to the pull-up, so a dropped enable reads high.
  assign lvl = ref_oe ? ref_pin : 1'b1;

  // Edge timer; the first period after reset is not meaningful.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_ff <= 1'b1;
      cnt_ff <= 16'h0001;
      per_ff <= 16'h0000;
      hi_ff <= 16'h0000;
      rise_ff <= 16'h0000;
    end else begin
      prev_ff <= lvl;
      if (lvl && !prev_ff) begin
        per_ff <= cnt_ff;
        cnt_ff <= 16'h0001;
        rise_ff <= rise_ff + 16'h0001;
      end else begin
        cnt_ff <= cnt_ff + 16'h0001;
        // A falling edge closes the high time.
        if (!lvl && prev_ff) begin
          hi_ff <= cnt_ff;
        end
      end
    end
  end
endmodule : rpg_rdc_model

`default_nettype wire

// ===== dv/rpg_top_tb.sv
/*
  Self-checking bench for the reference PWM generator: AHB-Lite register
  access, random and corner compare sets, and one converter model per pin.
  Assumes the single slave's hreadyout is the bus hready.
*/
`timescale 1ns/1ns
`default_nettype none

`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("mismatch %s expected %0h seen %0h", nm, e, g); end end

module rpg_top_tb;
  import rpg_pkg::*;
  logic hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0, clk_en = 1'b1;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rdat;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = RPG_HSIZE_WORD;
  logic hreadyout, hresp, pa_out, pa_oe, ac_out, ac_oe;
  logic [15:0] pa_per, pa_hi, pa_rise, ac_per, ac_hi, ac_rise, pp, pd, c0;
  int n_fail = 0, num_checks = 0, cyc = 0, seed = 32'hb7b6eca8;

  rpg_top dut (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .phase_adj_out(pa_out),
    .phase_adj_oe(pa_oe), .angle_corr_out(ac_out), .angle_corr_oe(ac_oe));
  rpg_rdc_model pa_m (.hclk(hclk), .hresetn(hresetn), .ref_pin(pa_out), .ref_oe(pa_oe),
    .per_ff(pa_per), .hi_ff(pa_hi), .rise_ff(pa_rise));
  rpg_rdc_model ac_m (.hclk(hclk), .hresetn(hresetn), .ref_pin(ac_out), .ref_oe(ac_oe),
    .per_ff(ac_per), .hi_ff(ac_hi), .rise_ff(ac_rise));

  // Clock of 4 ns period.
  initial begin
    forever #2 hclk = ~hclk;
  end

  // A hang is cut short well above the longest expected run.
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 90000) begin
      n_fail++;
      complete_run();
    end
  end

  // Expected length of a high phase or a period from a compare value.
  function automatic logic [15:0] exp_len(input logic [15:0] c);
    return c + 16'h0001;
  endfunction : exp_len

  // One AHB-Lite single transfer; called just after a rising edge.
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     input logic [2:0] sz);
    haddr <= {20'h0, a};
    htrans <= RPG_HTRANS_NONSEQ;
    hwrite <= wr;
    hsize <= sz;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rdat = hrdata;
    `CHK("hresp", 1'b0, hresp)
  endtask : bus

  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, RPG_HSIZE_WORD);
    `CHK("read data", e, rdat)
  endtask : rdchk

  // Load both compare pairs while stopped, start both, measure the pins.
  task automatic run_set(input logic [15:0] p0, d0, p1, d1);
    logic [15:0] r0, r1;
    int k;
    bus(1'b1, RPG_CTRL_OFS, 32'h0, RPG_HSIZE_WORD);
    bus(1'b1, RPG_PA_PER_OFS, {16'h0, p0}, RPG_HSIZE_WORD);
    bus(1'b1, RPG_PA_DUTY_OFS, {16'h0, d0}, RPG_HSIZE_WORD);
    bus(1'b1, RPG_AC_PER_OFS, {16'h0, p1}, RPG_HSIZE_WORD);
    bus(1'b1, RPG_AC_DUTY_OFS, {16'h0, d1}, RPG_HSIZE_WORD);
    bus(1'b1, RPG_CTRL_OFS, 32'h3, RPG_HSIZE_WORD);
    r0 = pa_rise;
    r1 = ac_rise;
    for (k = 0; k < 20000 && !(pa_rise - r0 >= 3 && ac_rise - r1 >= 3); k++) @(posedge hclk);
    `CHK("phase period", exp_len(p0), pa_per)
    `CHK("phase high", exp_len(d0), pa_hi)
    `CHK("corr period", exp_len(p1), ac_per)
    `CHK("corr high", exp_len(d1), ac_hi)
  endtask : run_set

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run

  // Main sequence.
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    `CHK("idle pins", 4'hf, {pa_out, pa_oe, ac_out, ac_oe})
    rdchk(RPG_STAT_OFS, 32'h30);
    rdchk(12'h100, 32'h0);
    // Printed compare sets, then edge cases and random sets.
    run_set(RPG_ALT_PA_PER, RPG_ALT_PA_DUTY, RPG_ALT_AC_PER, RPG_ALT_AC_DUTY);
    run_set(16'h0001, 16'h0000, 16'h0009, 16'h0008);
    for (int i = 0; i < 12; i++) begin
      pp = 16'h0002 + 16'($unsigned($random(seed)) % 200);
      pd = 16'($unsigned($random(seed)) % pp);
      run_set(pp, pd, pp + 16'h0007, pd);
    end
    bus(1'b1, RPG_PA_PER_OFS, 32'h55, RPG_HSIZE_WORD);
    rdchk(RPG_PA_PER_OFS, {16'h0, pp});
    bus(1'b1, RPG_CTRL_OFS, 32'h1, RPG_HSIZE_WORD);
    repeat (40) @(posedge hclk);
    bus(1'b0, RPG_CNT_OFS, 32'h0, RPG_HSIZE_WORD);
    `CHK("corr count", 16'h0, rdat[31:16])
    `CHK("corr pin", 1'b1, ac_out)
    bus(1'b1, RPG_CTRL_OFS, 32'h3, RPG_HSIZE_WORD);
    repeat (40) @(posedge hclk);
    bus(1'b1, RPG_CTRL_OFS, 32'h2, RPG_HSIZE_WORD);
    repeat (40) @(posedge hclk);
    bus(1'b0, RPG_CNT_OFS, 32'h0, RPG_HSIZE_WORD);
    `CHK("phase count", 16'h0, rdat[15:0])
    `CHK("phase pin", 1'b1, pa_out)
    bus(1'b1, RPG_CTRL_OFS, 32'h0, RPG_HSIZE_WORD);
    // a stopped channel takes new compares
    bus(1'b1, RPG_PA_PER_OFS, 32'h7, RPG_HSIZE_WORD);
    rdchk(RPG_PA_PER_OFS, 32'h7);
    rdchk(RPG_STAT_OFS, 32'h30);
    // Second reset: reset compares give 400 kHz and 200 kHz at 250 MHz.
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b1, RPG_CTRL_OFS, 32'h3, RPG_HSIZE_WORD);
    repeat (4000) @(posedge hclk);
    `CHK("phase 400k", 16'h0271, pa_per)
    `CHK("phase half", 16'h0138, pa_hi)
    `CHK("corr 200k", 16'h04e2, ac_per)
    `CHK("corr half", 16'h0271, ac_hi)
    // counting freezes while the clock enable is low; two enabled edges
    // lie between the first read's address phase and the freeze.
    bus(1'b0, RPG_CNT_OFS, 32'h0, RPG_HSIZE_WORD);
    c0 = 16'((rdat[15:0] + 32'h2) % (RPG_PA_PER_RST + 32'h1));
    clk_en <= 1'b0;
    repeat (50) @(posedge hclk);
    clk_en <= 1'b1;
    bus(1'b0, RPG_CNT_OFS, 32'h0, RPG_HSIZE_WORD);
    `CHK("frozen count", c0, rdat[15:0])
    complete_run();
  end
endmodule : rpg_top_tb

`default_nettype wire
